// >>> hdl/byte_fifo.sv
// Byte FIFO that holds the output bytes while bursts are grouped
`timescale 1ns/1ps
`default_nettype none
`include "fmt_cfg.svh"
module byte_fifo #(
    parameter int DEPTH = `FIFO_BYTES,
    parameter int AW = `FIFO_AW
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_clr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic [AW:0] o_level,
    output logic o_full,
    output logic o_empty
);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] lvl_q, lvl_d;
    logic do_wr, do_rd;

    // Compare at full level width so a power-of-two depth does not wrap to zero
    assign o_full = (lvl_q == (AW+1)'(DEPTH));
    assign o_empty = (lvl_q == '0);
    assign o_level = lvl_q;
    assign o_rdata = mem[rp_q];

    always_comb begin
        do_wr = i_wr && !o_full;
        do_rd = i_rd && !o_empty;
        wp_d = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d = do_rd ? rp_q + 1'b1 : rp_q;
        lvl_d = lvl_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        if (i_clr) begin
            wp_d = '0;
            rp_d = '0;
            lvl_d = '0;
        end
    end

    // Storage has no reset so it maps onto block memory
    always_ff @(posedge i_sys_clk) begin
        if (do_wr) begin
            mem[wp_q] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            lvl_q <= lvl_d;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/fmt_cfg.svh
// Constants for the pixel output formatter
`ifndef FMT_CFG_SVH
`define FMT_CFG_SVH
`define FIFO_BYTES 1024
`define FIFO_AW 10
`define RGB_565 3'h0
`define RGB_555 3'h1
`define RGB_444X 3'h2
`define RGB_X444 3'h3
`define WM_RESET 10'h100
`define DIV_RESET 4'h1
`define GRP_YUV 3'h4
`define GRP_RGB 3'h2
`define GRP_RAW_8P2 3'h2
`define GRP_RAW_SPARE 3'h1
`define GRP_NONE 3'h0
`endif

// >>> hdl/fmt_pkg.sv
// Types shared by the pixel output formatter
package fmt_pkg;
    typedef enum logic [1:0] {
        MODE_YUV = 2'h0,
        MODE_RGB = 2'h1,
        MODE_RAW = 2'h3
    } out_mode_t;

    typedef struct packed {
        logic [7:0] y0;
        logic [7:0] cb;
        logic [7:0] y1;
        logic [7:0] cr;
    } yuv_pair_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgb_pix_t;

    typedef struct packed {
        out_mode_t mode;
        logic [2:0] rgb_fmt;
        logic swap_yc;
        logic swap_crcb;
        logic raw_8p2;
        logic use_fifo;
        logic mipi_sel;
    } fmt_cfg_t;

    typedef enum logic [1:0] {
        ST_FILL = 2'h0,
        ST_BURST = 2'h1,
        ST_DRAIN = 2'h3
    } burst_st_t;
endpackage

// >>> hdl/pixel_out_fmt.sv
// Pixel output formatter: YUV/RGB/raw packing, burst buffer and pixel bus
// What this block does
// - Output direct or through buffer, per configuration; raw mode always direct
// - Output buffer holds 1024 bytes
// - Constant pixel clock during each line valid
// - Pixel rate set by the divider only; i_scaling is unused
// - Buffer fills to watermark, then bursts evenly
// - Buffered pixel clock free running, mode independent
// - YCbCr byte order follows the two swaps
// - RGB luma swap exchanges odd/even bytes
// - RGB chroma swap exchanges red and blue
// - 565 and 555 packings
// - 444x and x444 packings
// - Bypass sends raw 10-bit Bayer samples
// - First bypass: eight data plus two spare
// - 8+2 bypass: high byte then low bits
// - Watermark reprogrammable on size change
// - Only parallel or serial path active
`timescale 1ns/1ps
`default_nettype none
`include "fmt_cfg.svh"
module pixel_out_fmt
    import fmt_pkg::*;
#(
    parameter int DEPTH = `FIFO_BYTES,
    parameter int AW = `FIFO_AW
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire fmt_cfg_t i_cfg,
    input wire logic [AW-1:0] i_watermark,
    input wire logic i_wm_load,
    input wire logic [3:0] i_clk_div,
    input wire logic i_scaling,
    input wire logic i_line_end,
    input wire logic i_pix_valid,
    output logic o_pix_ready,
    input wire yuv_pair_t i_yuv,
    input wire rgb_pix_t i_rgb,
    input wire logic [9:0] i_raw,
    output logic [7:0] o_data,
    output logic [1:0] o_spare_data,
    output logic o_spare_oe,
    output logic o_line_valid,
    output logic o_pix_clk_en,
    output logic o_mipi_active
);
    // Pack an RGB pixel into odd (high) and even (low) bytes
    function automatic logic [15:0] pack_rgb(input rgb_pix_t p, input logic [2:0] f,
                                             input logic sw_c, input logic sw_yc);
        logic [7:0] r, b;
        logic [15:0] w;
        r = sw_c ? p.b : p.r;
        b = sw_c ? p.r : p.b;
        case (f)
            `RGB_565: w = {r[7:3], p.g[7:5], p.g[4:2], b[7:3]};
            `RGB_555: w = {1'b0, r[7:3], p.g[7:6], p.g[4:2], b[7:3]};
            `RGB_444X: w = {r[7:4], p.g[7:4], b[7:4], 4'h0};
            `RGB_X444: w = {4'h0, r[7:4], p.g[7:4], b[7:4]};
            default: w = {r[7:3], p.g[7:5], p.g[4:2], b[7:3]};
        endcase
        return sw_yc ? {w[7:0], w[15:8]} : w;
    endfunction

    logic [31:0] sh_q, sh_d;
    logic [2:0] left_q, left_d;
    logic [1:0] spare_q, spare_d;
    logic [3:0] div_q, div_d;
    logic tick;
    logic [AW-1:0] wm_q, wm_d;
    burst_st_t st_q, st_d;
    logic [7:0] data_q, data_d;
    logic [1:0] sp_q, sp_d;
    logic spoe_q, spoe_d, lv_q, lv_d, pce_q, pce_d, mipi_q, mipi_d;
    logic line_end_q, line_end_d;
    logic f_wr, f_rd, f_full, f_empty;
    logic [7:0] f_rdata, cur_byte;
    logic [AW:0] f_level;
    logic bufd, active, send_direct;

    byte_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_clr(!bufd),
        .i_wr(f_wr),
        .i_wdata(cur_byte),
        .i_rd(f_rd),
        .o_rdata(f_rdata),
        .o_level(f_level),
        .o_full(f_full),
        .o_empty(f_empty)
    );

    // Serializer: loads one pixel group, shifts out its bytes odd first
    always_comb begin
        active = !i_cfg.mipi_sel;
        bufd = active && i_cfg.use_fifo && (i_cfg.mode != MODE_RAW);
        tick = (div_q == '0);
        div_d = tick ? i_clk_div : div_q - 1'b1;
        sh_d = sh_q;
        left_d = left_q;
        spare_d = spare_q;
        cur_byte = sh_q[31:24];
        // Buffered path writes every cycle a group byte is left and the FIFO is not full; direct path only on pixel ticks
        send_direct = active && !bufd && tick;
        // Counter holds bytes still to leave, so the last byte of a group is not lost
        f_wr = bufd && (left_q != '0) && !f_full;
        if (left_q != '0) begin
            if (bufd ? !f_full : send_direct) begin
                sh_d = {sh_q[23:0], 8'h00};
                left_d = left_q - 1'b1;
            end
        end else if (i_pix_valid && active) begin
            spare_d = 2'h0;
            case (i_cfg.mode)
                MODE_YUV: begin
                    case ({i_cfg.swap_yc, i_cfg.swap_crcb})
                        2'b00: sh_d = {i_yuv.cb, i_yuv.y0, i_yuv.cr, i_yuv.y1};
                        2'b01: sh_d = {i_yuv.cr, i_yuv.y0, i_yuv.cb, i_yuv.y1};
                        2'b10: sh_d = {i_yuv.y0, i_yuv.cb, i_yuv.y1, i_yuv.cr};
                        default: sh_d = {i_yuv.y0, i_yuv.cr, i_yuv.y1, i_yuv.cb};
                    endcase
                    left_d = `GRP_YUV;
                end
                MODE_RGB: begin
                    sh_d = {pack_rgb(i_rgb, i_cfg.rgb_fmt, i_cfg.swap_crcb,
                                     i_cfg.swap_yc), 16'h0000};
                    left_d = `GRP_RGB;
                end
                MODE_RAW: begin
                    if (i_cfg.raw_8p2) begin
                        sh_d = {i_raw[9:2], 6'h00, i_raw[1:0], 16'h0000};
                        left_d = `GRP_RAW_8P2;
                    end else begin
                        sh_d = {i_raw[9:2], 24'h000000};
                        spare_d = i_raw[1:0];
                        left_d = `GRP_RAW_SPARE;
                    end
                end
                default: left_d = `GRP_NONE;
            endcase
        end
    end

    // Pixel input is accepted only once the previous group has shifted out
    assign o_pix_ready = (left_q == '0) && active;

    // Burst control and pin registers
    always_comb begin
        wm_d = i_wm_load ? i_watermark : wm_q;
        line_end_d = line_end_q | i_line_end;
        st_d = st_q;
        f_rd = 1'b0;
        data_d = data_q;
        sp_d = sp_q;
        spoe_d = active && (i_cfg.mode == MODE_RAW) && !i_cfg.raw_8p2;
        lv_d = 1'b0;
        pce_d = 1'b0;
        mipi_d = i_cfg.mipi_sel;
        if (bufd) begin
            pce_d = tick;
            case (st_q)
                ST_FILL: begin
                    if ({1'b0, wm_q} <= f_level && wm_q != '0) begin
                        st_d = ST_BURST;
                    end else if (line_end_q && !f_empty) begin
                        st_d = ST_DRAIN;
                        // A new line end in the same cycle wins over the clear
                        line_end_d = i_line_end;
                    end
                end
                ST_BURST, ST_DRAIN: begin
                    // Steady rate inside the burst; ends when the FIFO runs empty
                    if (tick) begin
                        if (f_empty) begin
                            st_d = ST_FILL;
                        end else begin
                            f_rd = 1'b1;
                            data_d = f_rdata;
                            lv_d = 1'b1;
                        end
                    end else begin
                        lv_d = lv_q;
                    end
                end
                default: st_d = ST_FILL;
            endcase
        end else begin
            st_d = ST_FILL;
            line_end_d = 1'b0;
            pce_d = active && tick;
            if (send_direct && (left_q != '0)) begin
                data_d = sh_q[31:24];
                sp_d = spare_q;
                lv_d = 1'b1;
            end else if (!tick) begin
                lv_d = lv_q;
            end
        end
        if (!active) begin
            lv_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sh_q <= '0;
            left_q <= '0;
            spare_q <= '0;
            div_q <= `DIV_RESET;
            wm_q <= `WM_RESET;
            st_q <= ST_FILL;
            data_q <= '0;
            sp_q <= '0;
            spoe_q <= 1'b0;
            lv_q <= 1'b0;
            pce_q <= 1'b0;
            mipi_q <= 1'b0;
            line_end_q <= 1'b0;
        end else begin
            sh_q <= sh_d;
            left_q <= left_d;
            spare_q <= spare_d;
            div_q <= div_d;
            wm_q <= wm_d;
            st_q <= st_d;
            data_q <= data_d;
            sp_q <= sp_d;
            spoe_q <= spoe_d;
            lv_q <= lv_d;
            pce_q <= pce_d;
            mipi_q <= mipi_d;
            line_end_q <= line_end_d;
        end
    end

    assign o_data = data_q;
    assign o_spare_data = sp_q;
    assign o_spare_oe = spoe_q;
    assign o_line_valid = lv_q;
    assign o_pix_clk_en = pce_q;
    assign o_mipi_active = mipi_q;
endmodule
`default_nettype wire

// >>> test/host_rx.sv
// Host receiver model on the parallel pixel bus
`timescale 1ns/1ps
`default_nettype none
module host_rx (
    input wire logic i_clk,
    input wire logic [7:0] i_data,
    input wire logic [1:0] i_spare,
    input wire logic i_line_valid,
    input wire logic i_tick
);
    logic [9:0] q[$];
    // Kept in arrival order so the odd byte leads each pixel
    always @(posedge i_clk) begin
        if (i_line_valid && i_tick)
            q.push_back({i_spare, i_data});
    end
endmodule
`default_nettype wire

// >>> test/pixel_out_fmt_properties.sv
// Port assertions for the pixel output formatter
`timescale 1ns/1ps
`default_nettype none
module pixel_out_fmt_props
    import fmt_pkg::*;
#(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire fmt_cfg_t i_cfg,
    input wire logic [AW-1:0] i_watermark,
    input wire logic i_wm_load,
    input wire logic [3:0] i_clk_div,
    input wire logic i_pix_valid,
    input wire logic o_pix_ready,
    input wire logic o_spare_oe,
    input wire logic o_line_valid,
    input wire logic o_pix_clk_en,
    input wire logic o_mipi_active
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    sequence rgb_pair;
        o_line_valid ##1 o_line_valid;
    endsequence
    sequence yuv_quad;
        o_line_valid [*4];
    endsequence
    sequence tick_gap;
        !o_pix_clk_en [*3] ##1 o_pix_clk_en;
    endsequence
    AST_MIPI_ACT: assert property ($past(i_rst_b) |-> o_mipi_active == $past(i_cfg.mipi_sel))
        else $error("serial select not mirrored");
    AST_MIPI_REFUSE: assert property (i_cfg.mipi_sel |-> !o_pix_ready)
        else $error("pixel taken while serial path active");
    AST_MIPI_QUIET: assert property (o_mipi_active |-> !o_line_valid)
        else $error("parallel bus active with serial path");
    AST_TICK_GAP: assert property (o_pix_clk_en && i_clk_div == 4'h3 |=> tick_gap)
        else $error("pixel tick spacing wrong");
    AST_DIRECT_LAT: assert property (i_pix_valid && o_pix_ready && !i_cfg.use_fifo
        && i_clk_div == 4'h0 |-> ##[1:4] o_line_valid)
        else $error("direct byte late");
    AST_READY_BUSY: assert property (i_pix_valid && o_pix_ready && !i_cfg.use_fifo
        && i_cfg.mode != MODE_RAW |=> !o_pix_ready)
        else $error("ready while group shifting");
    AST_RGB_PAIR: assert property ($rose(o_line_valid) && i_cfg.mode == MODE_RGB
        && !i_cfg.use_fifo && i_clk_div == 4'h0 |-> rgb_pair)
        else $error("rgb pixel not two bytes");
    AST_YUV_QUAD: assert property ($rose(o_line_valid) && i_cfg.mode == MODE_YUV
        && !i_cfg.use_fifo && i_clk_div == 4'h0 |-> yuv_quad)
        else $error("yuv pair not four bytes");
    AST_SPARE_OE: assert property (o_spare_oe && o_line_valid
        |-> i_cfg.mode == MODE_RAW && !i_cfg.raw_8p2)
        else $error("spare pins driven outside spare mode");
endmodule
bind pixel_out_fmt pixel_out_fmt_props #(.DEPTH(DEPTH), .AW(AW)) u_props (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cfg(i_cfg), .i_watermark(i_watermark),
    .i_wm_load(i_wm_load), .i_clk_div(i_clk_div), .i_pix_valid(i_pix_valid),
    .o_pix_ready(o_pix_ready), .o_spare_oe(o_spare_oe), .o_line_valid(o_line_valid),
    .o_pix_clk_en(o_pix_clk_en), .o_mipi_active(o_mipi_active));
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the pixel output formatter
`timescale 1ns/1ps
`default_nettype none
module tb
    import fmt_pkg::*;
;
    logic clk = 0, rst_b = 0, wm_load = 0, line_end = 0, valid = 0, scaling = 0, full10 = 0;
    fmt_cfg_t cfg = '0;
    logic [9:0] wm = 10'h008, raw = 10'h2b5;
    logic [3:0] div = 4'h0;
    yuv_pair_t yuv = '{y0: 8'h11, cb: 8'h22, y1: 8'h33, cr: 8'h44};
    rgb_pix_t rgb = '{r: 8'hd6, g: 8'h5b, b: 8'ha9};
    wire logic [7:0] data;
    wire logic [1:0] spare;
    wire logic oe, lv, tick, ready, mact;
    int error_cnt = 0, n_checks = 0;
    logic [9:0] exp_q[$];
    logic [31:0] yord [4] = '{32'h22114433, 32'h44112233, 32'h11223344, 32'h11443322};
    pixel_out_fmt uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg), .i_watermark(wm),
        .i_wm_load(wm_load), .i_clk_div(div), .i_scaling(scaling), .i_line_end(line_end),
        .i_pix_valid(valid), .o_pix_ready(ready), .i_yuv(yuv), .i_rgb(rgb), .i_raw(raw),
        .o_data(data), .o_spare_data(spare), .o_spare_oe(oe), .o_line_valid(lv),
        .o_pix_clk_en(tick), .o_mipi_active(mact));
    host_rx rx (.i_clk(clk), .i_data(data), .i_spare(spare), .i_line_valid(lv), .i_tick(tick));
    initial forever #20 clk = ~clk;
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Divider only changes under reset so the tick spacing never sees a half count
    task automatic do_reset(input logic [3:0] d);
        rst_b = 0;
        div = d;
        repeat (10) @(negedge clk);
        rst_b = 1;
    endtask
    task automatic send();
        int n;
        n = 0;
        @(negedge clk);
        valid = 1;
        while (!ready && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        valid = 0;
    endtask
    task automatic check_rx();
        repeat (30) @(negedge clk);
        chk(16'(rx.q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) chk(full10 ? rx.q[i] : rx.q[i][7:0], exp_q[i]);
        rx.q.delete();
        exp_q.delete();
    endtask
    function automatic logic [15:0] rgb_exp(input logic [1:0] f, input logic yc,
        input logic cc, input rgb_pix_t p);
        logic [7:0] r, b;
        logic [15:0] w;
        r = cc ? p.b : p.r;
        b = cc ? p.r : p.b;
        case (f)
            2'h0: w = {r[7:3], p.g[7:5], p.g[4:2], b[7:3]};
            2'h1: w = {1'b0, r[7:3], p.g[7:6], p.g[4:2], b[7:3]};
            2'h2: w = {r[7:4], p.g[7:4], b[7:4], 4'h0};
            default: w = {4'h0, r[7:4], p.g[7:4], b[7:4]};
        endcase
        return yc ? {w[7:0], w[15:8]} : w;
    endfunction
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        logic [15:0] w;
        int n;
        do_reset(4'h0);
        for (int k = 0; k < 4; k++) begin
            {cfg.swap_yc, cfg.swap_crcb} = k[1:0];
            send();
            for (int j = 3; j >= 0; j--) exp_q.push_back(10'(yord[k][8*j +: 8]));
            check_rx();
        end
        $display("yuv ordering done");
        cfg.mode = MODE_RGB;
        for (int k = 0; k < 16; k++) begin
            cfg.rgb_fmt = 3'(k[3:2]);
            {cfg.swap_yc, cfg.swap_crcb} = k[1:0];
            send();
            w = rgb_exp(k[3:2], k[1], k[0], rgb);
            exp_q = '{10'(w[15:8]), 10'(w[7:0])};
            check_rx();
        end
        $display("rgb packing done");
        cfg = '0;
        cfg.mode = MODE_RAW;
        cfg.raw_8p2 = 1;
        send();
        exp_q = '{10'h0ad, 10'h001};
        check_rx();
        chk(16'(oe), 16'h0000);
        cfg.raw_8p2 = 0;
        full10 = 1;
        send();
        exp_q = '{10'h1ad};
        check_rx();
        chk(16'(oe), 16'h0001);
        full10 = 0;
        $display("raw bypass done");
        cfg = '0;
        cfg.mode = MODE_RGB;
        cfg.use_fifo = 1;
        wm_load = 1;
        @(negedge clk);
        wm_load = 0;
        repeat (3) send();
        check_rx();
        send();
        w = rgb_exp(2'h0, 1'b0, 1'b0, rgb);
        repeat (4) exp_q = {exp_q, 10'(w[15:8]), 10'(w[7:0])};
        check_rx();
        send();
        check_rx();
        line_end = 1;
        @(negedge clk);
        line_end = 0;
        exp_q = '{10'(w[15:8]), 10'(w[7:0])};
        check_rx();
        $display("buffered bursts done");
        scaling = 1;
        do_reset(4'h3);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += tick;
        end
        chk(16'(n), 16'h000a);
        scaling = 0;
        do_reset(4'h0);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += tick;
        end
        chk(16'(n), 16'h0027);
        $display("pixel clock rate done");
        cfg.mipi_sel = 1;
        repeat (2) @(negedge clk);
        chk({ready, mact}, 16'h0001);
        valid = 1;
        repeat (10) @(negedge clk);
        valid = 0;
        check_rx();
        $display("serial select done");
        report_and_stop();
    end
endmodule
`default_nettype wire
